// File: rtl/ipm_defines.svh
`ifndef IPM_DEFINES_SVH
`define IPM_DEFINES_SVH

// ****************************************************************
// Register indices and byte addresses.
// ****************************************************************
// Printed offsets are word indices; the byte address is four times the index.
`define IPM_IDX_PIN_SEL      32'h0000_0462
`define IPM_IDX_CLOCK_OUTPUT_PIN_SEL   32'h0000_0463
`define IPM_IDX_STRAP        32'h0000_0467
`define IPM_ADDR_PIN_SEL     (`IPM_IDX_PIN_SEL << 2)
`define IPM_ADDR_CLOCK_OUTPUT_PIN_SEL  (`IPM_IDX_CLOCK_OUTPUT_PIN_SEL << 2)
`define IPM_ADDR_STRAP       (`IPM_IDX_STRAP << 2)

// ****************************************************************
// Field positions.
// ****************************************************************
`define IPM_A_FUNC_LSB       0
`define IPM_A_CLK_LSB        4
`define IPM_B_FUNC_LSB       8
`define IPM_B_CLK_LSB        12
`define IPM_CO_FUNC_LSB      0
`define IPM_CO_CLK_LSB       4
`define IPM_ST_LED1_LSB      14
`define IPM_ST_RXDV_LSB      12
`define IPM_ST_RXER_LSB      10
`define IPM_ST_LED0_LSB      8
`define IPM_ST_RXD0_LSB      6
`define IPM_ST_RXD1_LSB      4
`define IPM_ST_RXD2_LSB      2
`define IPM_ST_RXD3_LSB      0

// ****************************************************************
// Writable masks and reset values.
// ****************************************************************
`define IPM_PIN_SEL_MASK     16'h7777
`define IPM_CLOCK_OUTPUT_PIN_SEL_MASK  16'h00F7
`define IPM_PIN_SEL_RESET    16'h0000
`define IPM_CLOCK_OUTPUT_PIN_SEL_RESET 16'h0001
`define IPM_STRAP_RESET      16'h0000

// ****************************************************************
// Timing counts.
// ****************************************************************
// Cycles after reset release before the strap synchronisers hold pin levels.
`define IPM_STRAP_SETTLE     2'h2

`endif

// File: rtl/ipm_pkg.sv
`default_nettype none

package ipm_pkg;

  // Function routed onto an output pin.
  typedef enum logic [2:0] {
    IPM_FUNC_OWN   = 3'h0,
    IPM_FUNC_CLOCK = 3'h1,
    IPM_FUNC_WAKE  = 3'h2,
    IPM_FUNC_UV    = 3'h3,
    IPM_FUNC_TS_TX = 3'h4,
    IPM_FUNC_TS_RX = 3'h5,
    IPM_FUNC_LOW   = 3'h6,
    IPM_FUNC_HIGH  = 3'h7
  } ipm_func_e;

  // Strap mode codes; 01 and 10 are reserved for the role and autonomy straps.
  typedef enum logic [1:0] {
    IPM_MODE1 = 2'h0,
    IPM_MODE2 = 2'h1,
    IPM_MODE3 = 2'h2,
    IPM_MODE4 = 2'h3
  } ipm_mode_e;

  // Index of each routed pin.
  typedef logic [1:0] ipm_pin_t;

endpackage

`default_nettype wire

// File: rtl/ipm_strap_latch.sv
`timescale 1ns/10ps
`default_nettype none
`include "ipm_defines.svh"

// Synchronises the strap mode codes, latches them once after reset and decodes them.
module ipm_strap_latch (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [15:0] strap_level_codes,
  output logic      [15:0] strap_reg,
  output logic             strap_done,
  output logic      [3:0]  management_address_bits,
  output logic      [2:0]  interface_select_bits,
  output logic      [2:0]  test_bits,
  output logic             autonomous_disabled,
  output logic             link_master,
  output logic             strap_reserved_mode
);

  logic [15:0] sync1_reg;
  logic [15:0] sync2_reg;
  logic [1:0]  settle_reg;

  // Two-stage synchroniser for the strap codes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
    end else if (ce) begin
      sync1_reg <= strap_level_codes;
      sync2_reg <= sync1_reg;
    end
  end

  // Capture once the synchroniser has filled, then hold until the next reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 2'h0;
      strap_done <= 1'b0;
      strap_reg  <= `IPM_STRAP_RESET;
    end else if (ce && !strap_done) begin
      if (settle_reg == `IPM_STRAP_SETTLE) begin
        strap_done <= 1'b1;
        strap_reg  <= sync2_reg;
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // Mode n maps to (high bit, high xor low) of its code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      management_address_bits <= 4'h0;
      interface_select_bits   <= 3'h0;
      test_bits               <= 3'h0;
      autonomous_disabled     <= 1'b0;
      link_master             <= 1'b0;
      strap_reserved_mode     <= 1'b0;
    end else if (ce) begin
      management_address_bits[0] <= strap_reg[`IPM_ST_RXDV_LSB+1];
      management_address_bits[2] <= ^strap_reg[`IPM_ST_RXDV_LSB +: 2];
      management_address_bits[1] <= strap_reg[`IPM_ST_RXER_LSB+1];
      management_address_bits[3] <= ^strap_reg[`IPM_ST_RXER_LSB +: 2];
      interface_select_bits <= {strap_reg[`IPM_ST_RXD2_LSB+1], strap_reg[`IPM_ST_RXD1_LSB+1],
                                strap_reg[`IPM_ST_RXD0_LSB+1]};
      test_bits <= {^strap_reg[`IPM_ST_RXD2_LSB +: 2], ^strap_reg[`IPM_ST_RXD1_LSB +: 2],
                    ^strap_reg[`IPM_ST_RXD0_LSB +: 2]};
      autonomous_disabled <= (strap_reg[`IPM_ST_LED1_LSB +: 2] == ipm_pkg::IPM_MODE4);
      link_master <= (strap_reg[`IPM_ST_LED0_LSB +: 2] == ipm_pkg::IPM_MODE4);
      strap_reserved_mode <= (^strap_reg[`IPM_ST_LED1_LSB +: 2])
                             || (^strap_reg[`IPM_ST_LED0_LSB +: 2])
                             || (strap_reg[`IPM_ST_RXD3_LSB +: 2] != ipm_pkg::IPM_MODE1);
    end
  end

  a_strap_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (strap_done && $past(strap_done)) |-> $stable(strap_reg))
    else $error("Latched strap value changed after capture.");

  a_addr_decode: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> (management_address_bits[2] == ($past(strap_reg[13]) ^ $past(strap_reg[12])))
      && (management_address_bits[1] == $past(strap_reg[11])))
    else $error("Management address decode is wrong.");

  a_iface_decode: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> (interface_select_bits[1] == $past(strap_reg[5]))
      && (test_bits[0] == ($past(strap_reg[7]) ^ $past(strap_reg[6]))))
    else $error("Interface select or test decode is wrong.");

endmodule // ipm_strap_latch

`default_nettype wire

// File: rtl/ipm_top.sv
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "ipm_defines.svh"

// What this block does
// - Each indicator pin drives the function picked by its 3-bit select, resetting to its own indicator.
// - The clock-output pin's 4-bit clock select picks crystal at zero and symbol clock at one.
// - The clock-output pin's function select resets to clock and its code zero routes the third indicator.
// - The autonomy strap field reads 00 when enabled and 11 when disabled, other codes reserved.
// - The role strap field reads 00 for slave and 11 for master, other codes reserved.
// - The receive-valid strap code maps to management address bits 0 and 2.
// - The receive-error strap code maps to management address bits 1 and 3.
// - The receive-data-0 strap code maps to interface-select bit 0 and test bit 0.
// - Strap fields are read-only and hold latched strap codes, not pin levels.
// - Receive-data-1 and -2 strap codes map likewise to interface-select and test bits 1 and 2.
// - The receive-data-3 strap field has 00 as its only valid mode.
module ipm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        indicator_a_src,
  input  wire logic        indicator_b_src,
  input  wire logic        indicator_c_src,
  input  wire logic        crystal_input_clock,
  input  wire logic        transmit_symbol_clock,
  input  wire logic        wake_event,
  input  wire logic        undervoltage_flag,
  input  wire logic        ts_transmit_pulse,
  input  wire logic        ts_receive_pulse,
  input  wire logic [15:0] strap_level_codes,
  output logic             indicator_pin_a_out,
  output logic             indicator_pin_a_oe_n,
  output logic             indicator_pin_b_out,
  output logic             indicator_pin_b_oe_n,
  output logic             clock_output_pin_out,
  output logic             clock_output_pin_oe_n,
  output logic      [3:0]  management_address_bits,
  output logic      [2:0]  interface_select_bits,
  output logic      [2:0]  test_bits,
  output logic             autonomous_disabled,
  output logic             link_master,
  output logic             strap_reserved_mode
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [15:0]         pin_sel_reg;
  logic [15:0]         clock_output_pin_sel_reg;
  logic [15:0]         strap_reg;
  logic                strap_done;
  logic [1:0]          clk1_reg;
  logic [1:0]          clk2_reg;
  logic [2:0]          pin_out_reg;
  logic                oe_n_reg;
  logic                setup_phase;
  logic                access_done;
  logic                wr_pin_sel;
  logic                wr_clock_output_pin_sel;
  logic [15:0]         wdata_masked;
  logic [15:0]         rd_next;
  logic                err_next;
  ipm_pkg::ipm_func_e  func_sel [3];
  logic [2:0]          clk_level;
  logic [2:0]          own_level;

  // ****************************************************************
  // Strap capture and decode.
  // ****************************************************************
  ipm_strap_latch u_strap (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .ce                      (ce),
    .strap_level_codes       (strap_level_codes),
    .strap_reg               (strap_reg),
    .strap_done              (strap_done),
    .management_address_bits (management_address_bits),
    .interface_select_bits   (interface_select_bits),
    .test_bits               (test_bits),
    .autonomous_disabled     (autonomous_disabled),
    .link_master             (link_master),
    .strap_reserved_mode     (strap_reserved_mode)
  );

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  // Phase decode and write strobes; writes land only at the completing edge.
  assign setup_phase   = psel && !penable;
  assign access_done   = psel && penable && pready;
  assign wr_pin_sel    = access_done && pwrite && (paddr == `IPM_ADDR_PIN_SEL);
  assign wr_clock_output_pin_sel = access_done && pwrite && (paddr == `IPM_ADDR_CLOCK_OUTPUT_PIN_SEL);

  // Byte lanes above bit 15 do not exist, so only the two low strobes apply.
  always_comb begin
    wdata_masked = 16'h0000;
    for (int i = 0; i < 2; i++) begin
      wdata_masked[i*8 +: 8] = pstrb[i] ? pwdata[i*8 +: 8] : 8'h00;
    end
  end

  // Read mux; the strap word is read-only and unknown addresses raise an error.
  always_comb begin
    rd_next  = 16'h0000;
    err_next = 1'b0;
    unique case (paddr)
      `IPM_ADDR_PIN_SEL:    rd_next = pin_sel_reg;
      `IPM_ADDR_CLOCK_OUTPUT_PIN_SEL: rd_next = clock_output_pin_sel_reg;
      `IPM_ADDR_STRAP:      rd_next = strap_reg;
      default:              err_next = 1'b1;
    endcase
  end

  // Answer is prepared during setup and shown throughout the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      if (setup_phase) begin
        pready  <= 1'b1;
        pslverr <= err_next;
        prdata  <= (pwrite || err_next) ? 32'h0000_0000 : {16'h0000, rd_next};
      end else if (access_done) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Output control registers.
  // ****************************************************************
  // Indicator pin selects; reserved bits stay zero whatever is written.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sel_reg <= `IPM_PIN_SEL_RESET;
    end else if (ce && wr_pin_sel) begin
      pin_sel_reg <= (wdata_masked & `IPM_PIN_SEL_MASK)
                   | (pin_sel_reg & ~(`IPM_PIN_SEL_MASK) & 16'h0000)
                   | (pin_sel_reg & `IPM_PIN_SEL_MASK & {{8{~pstrb[1]}}, {8{~pstrb[0]}}});
    end
  end

  // Clock-output pin select; resets to the clock function.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_output_pin_sel_reg <= `IPM_CLOCK_OUTPUT_PIN_SEL_RESET;
    end else if (ce && wr_clock_output_pin_sel) begin
      clock_output_pin_sel_reg <= (wdata_masked & `IPM_CLOCK_OUTPUT_PIN_SEL_MASK)
                      | (clock_output_pin_sel_reg & `IPM_CLOCK_OUTPUT_PIN_SEL_MASK
                         & {{8{~pstrb[1]}}, {8{~pstrb[0]}}});
    end
  end

  // ****************************************************************
  // Clock sampling.
  // ****************************************************************
  // Both clocks come from outside this domain and pass two flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk1_reg <= 2'h0;
      clk2_reg <= 2'h0;
    end else if (ce) begin
      clk1_reg <= {transmit_symbol_clock, crystal_input_clock};
      clk2_reg <= clk1_reg;
    end
  end

  // ****************************************************************
  // Per-pin function selection.
  // ****************************************************************
  // Pin 0 and 1 are the indicator pins, pin 2 is the clock-output pin.
  assign func_sel[0] = ipm_pkg::ipm_func_e'(pin_sel_reg[`IPM_A_FUNC_LSB +: 3]);
  assign func_sel[1] = ipm_pkg::ipm_func_e'(pin_sel_reg[`IPM_B_FUNC_LSB +: 3]);
  assign func_sel[2] = ipm_pkg::ipm_func_e'(clock_output_pin_sel_reg[`IPM_CO_FUNC_LSB +: 3]);
  assign own_level   = {indicator_c_src, indicator_b_src, indicator_a_src};

  // Clock choice per pin; codes beyond one pick no clock and hold the pin low.
  always_comb begin
    clk_level = 3'h0;
    unique case (pin_sel_reg[`IPM_A_CLK_LSB +: 3])
      3'h0:    clk_level[0] = clk2_reg[0];
      3'h1:    clk_level[0] = clk2_reg[1];
      default: clk_level[0] = 1'b0;
    endcase
    unique case (pin_sel_reg[`IPM_B_CLK_LSB +: 3])
      3'h0:    clk_level[1] = clk2_reg[0];
      3'h1:    clk_level[1] = clk2_reg[1];
      default: clk_level[1] = 1'b0;
    endcase
    unique case (clock_output_pin_sel_reg[`IPM_CO_CLK_LSB +: 4])
      4'h0:    clk_level[2] = clk2_reg[0];
      4'h1:    clk_level[2] = clk2_reg[1];
      default: clk_level[2] = 1'b0;
    endcase
  end

  // One registered multiplexer per routed pin.
  for (genvar g = 0; g < 3; g++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_out_reg[g] <= 1'b0;
      end else if (ce) begin
        unique case (func_sel[g])
          ipm_pkg::IPM_FUNC_OWN:   pin_out_reg[g] <= own_level[g];
          ipm_pkg::IPM_FUNC_CLOCK: pin_out_reg[g] <= clk_level[g];
          ipm_pkg::IPM_FUNC_WAKE:  pin_out_reg[g] <= wake_event;
          ipm_pkg::IPM_FUNC_UV:    pin_out_reg[g] <= undervoltage_flag;
          ipm_pkg::IPM_FUNC_TS_TX: pin_out_reg[g] <= ts_transmit_pulse;
          ipm_pkg::IPM_FUNC_TS_RX: pin_out_reg[g] <= ts_receive_pulse;
          ipm_pkg::IPM_FUNC_LOW:   pin_out_reg[g] <= 1'b0;
          ipm_pkg::IPM_FUNC_HIGH:  pin_out_reg[g] <= 1'b1;
        endcase
      end
    end
  end

  // Pins stay released while straps are sensed, then drive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_reg <= 1'b1;
    end else if (ce) begin
      oe_n_reg <= !strap_done;
    end
  end

  // Pin outputs come straight from the registers above.
  assign indicator_pin_a_out   = pin_out_reg[0];
  assign indicator_pin_b_out   = pin_out_reg[1];
  assign clock_output_pin_out  = pin_out_reg[2];
  assign indicator_pin_a_oe_n  = oe_n_reg;
  assign indicator_pin_b_oe_n  = oe_n_reg;
  assign clock_output_pin_oe_n = oe_n_reg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_pin_a_high: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pin_sel_reg[2:0] == 3'h7) |=> indicator_pin_a_out)
    else $error("Indicator pin a not high under constant-high select.");

  a_pin_b_low: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pin_sel_reg[10:8] == 3'h6) |=> !indicator_pin_b_out)
    else $error("Indicator pin b not low under constant-low select.");

  a_pin_a_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pin_sel_reg[2:0] == 3'h2) |=> indicator_pin_a_out == $past(wake_event))
    else $error("Indicator pin a does not follow the wake event.");

  a_led_clk_xtal: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pin_sel_reg[10:8] == 3'h1 && pin_sel_reg[14:12] == 3'h0)
      |=> indicator_pin_b_out == $past(clk2_reg[0]))
    else $error("Indicator pin b clock is not the crystal clock.");

  a_clock_output_pin_tclk: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && clock_output_pin_sel_reg[2:0] == 3'h1 && clock_output_pin_sel_reg[7:4] == 4'h1)
      |=> clock_output_pin_out == $past(clk2_reg[1]))
    else $error("Clock output pin is not the symbol clock.");

  a_clock_output_pin_led_c: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && clock_output_pin_sel_reg[2:0] == 3'h0) |=> clock_output_pin_out == $past(indicator_c_src))
    else $error("Clock output pin does not carry the third indicator.");

  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_sel_reg & ~16'h7777) == 16'h0000 && (clock_output_pin_sel_reg & ~16'h00F7) == 16'h0000)
    else $error("Reserved control bits are not zero.");

  a_strap_readonly: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && paddr == `IPM_ADDR_STRAP) |=> $stable(strap_reg))
    else $error("Write changed the strap register.");

  a_pin_a_tclk: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pin_sel_reg[2:0] == 3'h1 && pin_sel_reg[6:4] == 3'h1)
      |=> indicator_pin_a_out == $past(clk2_reg[1]))
    else $error("Indicator pin a clock is not the symbol clock.");

  a_pin_b_ts_rx: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && pin_sel_reg[10:8] == 3'h5) |=> indicator_pin_b_out == $past(ts_receive_pulse))
    else $error("Indicator pin b does not follow the receive timestamp pulse.");

  a_clock_output_pin_resv: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && clock_output_pin_sel_reg[2:0] == 3'h1 && clock_output_pin_sel_reg[7:4] > 4'h1)
      |=> !clock_output_pin_out)
    else $error("Clock output pin is not low under a reserved clock code.");

  a_pins_driven: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && strap_done) |=> !indicator_pin_a_oe_n && !clock_output_pin_oe_n)
    else $error("Pins are not driven after the straps were latched.");

endmodule // ipm_top

`default_nettype wire

// File: tb/ipm_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ipm_defines.svh"

module ipm_top_tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb, mab;
  logic [8:0]  src;
  logic [15:0] straps;
  logic        pa, pb, pc, pa_n, pb_n, pc_n, adis, lmas, rsv;
  logic [2:0]  isb, tsb;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [8:0]  pats [3] = '{9'h1A6, 9'h049, 9'h0F3};

  ipm_top ipm_top_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .indicator_a_src(src[0]), .indicator_b_src(src[1]),
    .indicator_c_src(src[2]), .crystal_input_clock(src[3]), .transmit_symbol_clock(src[4]),
    .wake_event(src[5]), .undervoltage_flag(src[6]), .ts_transmit_pulse(src[7]),
    .ts_receive_pulse(src[8]), .strap_level_codes(straps), .indicator_pin_a_out(pa),
    .indicator_pin_a_oe_n(pa_n), .indicator_pin_b_out(pb), .indicator_pin_b_oe_n(pb_n),
    .clock_output_pin_out(pc), .clock_output_pin_oe_n(pc_n), .management_address_bits(mab),
    .interface_select_bits(isb), .test_bits(tsb), .autonomous_disabled(adis),
    .link_master(lmas), .strap_reserved_mode(rsv)
  );

  // ****************************************************************
  // Clock, timeout and shared helpers.
  // ****************************************************************
  // The clock toggles every 2 ns, a period of 4 ns.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // A hung run is cut short and counted as a mismatch.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic [15:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    straps <= s;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask

  // Expected pin level for a function code.
  function automatic logic pick(input int f, input logic own, input logic clk);
    case (f)
      0: return own;
      1: return clk;
      2: return src[5];
      3: return src[6];
      4: return src[7];
      5: return src[8];
      6: return 1'b0;
      default: return 1'b1;
    endcase
  endfunction

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset_values;
    apb(1'b0, `IPM_ADDR_PIN_SEL, 32'h0, 4'hF);
    check(rd, 32'h0000_0000);
    apb(1'b0, `IPM_ADDR_CLOCK_OUTPUT_PIN_SEL, 32'h0, 4'hF);
    check(rd, 32'h0000_0001);
    check({pa_n, pb_n, pc_n}, 32'h0);
  endtask

  task automatic t_masks;
    apb(1'b1, `IPM_ADDR_PIN_SEL, 32'hFFFF_FFFF, 4'h1);
    apb(1'b0, `IPM_ADDR_PIN_SEL, 32'h0, 4'hF);
    check(rd, 32'h0000_0077);
    apb(1'b1, `IPM_ADDR_PIN_SEL, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, `IPM_ADDR_PIN_SEL, 32'h0, 4'hF);
    check(rd, 32'h0000_7777);
    apb(1'b1, `IPM_ADDR_CLOCK_OUTPUT_PIN_SEL, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, `IPM_ADDR_CLOCK_OUTPUT_PIN_SEL, 32'h0, 4'hF);
    check(rd, 32'h0000_00F7);
    apb(1'b0, 32'h0000_0000, 32'h0, 4'hF);
    check(rd, 32'h0);
    check(er, 32'h1);
  endtask

  // Every function code on all three pins, with several source patterns.
  task automatic t_pins;
    for (int p = 0; p < 3; p++) begin
      for (int f = 0; f < 8; f++) begin
        src <= pats[p];
        apb(1'b1, `IPM_ADDR_PIN_SEL, ((1 - p % 2) << 12) | (f << 8) | ((p % 2) << 4) | f, 4'hF);
        apb(1'b1, `IPM_ADDR_CLOCK_OUTPUT_PIN_SEL, ((p % 2) << 4) | f, 4'hF);
        repeat (6) @(posedge pclk);
        check(pa, pick(f, src[0], (p % 2) ? src[4] : src[3]));
        check(pb, pick(f, src[1], (p % 2) ? src[3] : src[4]));
        check(pc, pick(f, src[2], (p % 2) ? src[4] : src[3]));
      end
    end
    // A reserved clock code holds the clock-output pin low even with every clock high.
    src <= 9'h1FF;
    apb(1'b1, `IPM_ADDR_CLOCK_OUTPUT_PIN_SEL, 32'h0000_0021, 4'hF);
    repeat (4) @(posedge pclk);
    check(pc, 32'h0);
  endtask

  // Lowering the clock enable freezes the pins until it rises again.
  task automatic t_freeze;
    apb(1'b1, `IPM_ADDR_PIN_SEL, 32'h0000_0000, 4'hF);
    src <= 9'h000;
    repeat (4) @(posedge pclk);
    ce <= 1'b0;
    src <= 9'h001;
    repeat (4) @(posedge pclk);
    check(pa, 32'h0);
    ce <= 1'b1;
    repeat (3) @(posedge pclk);
    check(pa, 32'h1);
  endtask

  // Latch one strap set, check its decodes, then show it holds and ignores writes.
  task automatic t_straps(input logic [15:0] s);
    do_reset(s);
    apb(1'b0, `IPM_ADDR_STRAP, 32'h0, 4'hF);
    check(rd, {16'h0000, s});
    check(mab, {s[11] ^ s[10], s[13] ^ s[12], s[11], s[13]});
    check(isb[0], s[7]);
    check(tsb[0], s[7] ^ s[6]);
    check({isb[2:1], tsb[2:1]}, {s[3], s[5], s[3] ^ s[2], s[5] ^ s[4]});
    check(adis, s[15:14] == 2'b11);
    check(lmas, s[9:8] == 2'b11);
    check(rsv, (s[15] ^ s[14]) | (s[9] ^ s[8]) | (s[1:0] != 2'b00));
    straps <= ~s;
    apb(1'b1, `IPM_ADDR_STRAP, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, `IPM_ADDR_STRAP, 32'h0, 4'hF);
    check(rd, {16'h0000, s});
    check(er, 32'h0);
  endtask

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    src = 9'h000;
    straps = 16'hDB6C;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    t_reset_values();
    t_masks();
    t_pins();
    t_freeze();
    t_straps(16'hDB6C);
    t_straps(16'h3001);
    t_straps(16'h4D00);
    t_straps(16'hA6B7);
    finish_test();
  end
endmodule // ipm_top_tb_top

`default_nettype wire
